// ---- inc/ftsc_pkg.sv ----
// package: register map, field positions, reset values and state layout of the free timer status/control block
package ftsc_pkg;

	// byte addresses on the 8-bit register port
	localparam logic [15:0] ADDR_IRQ_EN     = 16'hFF90;
	localparam logic [15:0] ADDR_STATUS     = 16'hFF91;
	localparam logic [15:0] ADDR_COUNT_HI   = 16'hFF92;
	localparam logic [15:0] ADDR_COUNT_LO   = 16'hFF93;
	localparam logic [15:0] ADDR_COMPARE_HI = 16'hFF94;
	localparam logic [15:0] ADDR_COMPARE_LO = 16'hFF95;
	localparam logic [15:0] ADDR_CONTROL    = 16'hFF96;
	localparam logic [15:0] ADDR_OUT_CTRL   = 16'hFF97;
	localparam logic [15:0] ADDR_CAP_A_HI   = 16'hFF98;
	localparam logic [15:0] ADDR_CAP_A_LO   = 16'hFF99;
	localparam logic [15:0] ADDR_CAP_B_HI   = 16'hFF9A;
	localparam logic [15:0] ADDR_CAP_B_LO   = 16'hFF9B;
	localparam logic [15:0] ADDR_CAP_C_HI   = 16'hFF9C;
	localparam logic [15:0] ADDR_CAP_C_LO   = 16'hFF9D;
	localparam logic [15:0] ADDR_CAP_D_HI   = 16'hFF9E;
	localparam logic [15:0] ADDR_CAP_D_LO   = 16'hFF9F;

	// timer_event_status bit positions
	localparam int ST_CAP_A     = 7;
	localparam int ST_CAP_B     = 6;
	localparam int ST_CAP_C     = 5;
	localparam int ST_CAP_D     = 4;
	localparam int ST_CMP_A     = 3;
	localparam int ST_CMP_B     = 2;
	localparam int ST_WRAP      = 1;
	localparam int ST_CLR_MATCH = 0;

	// timer_control bit positions
	localparam int CT_EDGE_A = 7;
	localparam int CT_EDGE_B = 6;
	localparam int CT_EDGE_C = 5;
	localparam int CT_EDGE_D = 4;
	localparam int CT_BUF_A  = 3;
	localparam int CT_BUF_B  = 2;
	localparam int CT_CKS_HI = 1;
	localparam int CT_CKS_LO = 0;

	// output-control register: only the compare-select bit steers this block
	localparam int OC_SEL_B = 4;

	// reset values, read fill values and counter constants
	localparam logic [7:0]  STATUS_RST    = 8'h00;
	localparam logic [7:0]  CONTROL_RST   = 8'h00;
	localparam logic [7:0]  IRQ_EN_RST    = 8'h01;
	localparam logic [7:0]  OUT_CTRL_FILL = 8'hE0;
	localparam logic [7:0]  UNMAPPED_READ = 8'h00;
	localparam logic [15:0] COUNT_ALL_ONE = 16'hFFFF;
	localparam logic [15:0] COUNT_ONE     = 16'h0001;

	// counter clock select codes
	typedef enum logic [1:0] {
		CKS_DIV2  = 2'b00,
		CKS_DIV8  = 2'b01,
		CKS_DIV32 = 2'b10,
		CKS_EXT   = 2'b11
	} ftsc_cks_t;

	// pin vector order: capture a..d, external count clock
	localparam int PIN_A   = 0;
	localparam int PIN_B   = 1;
	localparam int PIN_C   = 2;
	localparam int PIN_D   = 3;
	localparam int PIN_EXT = 4;

	typedef struct packed {
		logic [7:0]  status;
		logic [7:0]  control;
		logic [7:0]  irq_en;
		logic [4:0]  out_ctrl;
		logic [15:0] count;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [15:0] cap_a;
		logic [15:0] cap_b;
		logic [15:0] cap_c;
		logic [15:0] cap_d;
		logic [7:0]  temp;
		logic [4:0]  prescale;
		logic [4:0]  sync0;
		logic [4:0]  sync1;
		logic [4:0]  sync2;
		logic [4:0]  level;
		logic [7:0]  rdata;
		logic [6:0]  irq;
	} ftsc_state_t;

endpackage

// ---- hw/ftsc_timer.sv ----
// free-running timer: event flags, capture/compare channels, control and register port
// Operation
// - status bits 7..1 ignore written ones; a written zero clears, only hardware sets
// - status register returns to zero on reset and in standby
// - capture A without buffering loads counter into capture register A, sets flag
// - capture A with buffering shifts register A into C, then loads A
// - capture B sets its flag, loads B; buffering shifts old B into D
// - selected edge on input C sets flag C; captures only without buffer A
// - selected edge on input D sets flag D; captures only without buffer B
// - counter equal to compare register A sets compare flag A
// - counter equal to compare register B sets compare flag B
// - counter rolling from all ones to zero sets the wrap flag
// - clear-on-match bit set clears counter at compare match A
// - control register returns to zero on reset and in standby
// - edge select A picks falling (0) or rising (1) edge of input A
// - edge select B picks falling (0) or rising (1) edge of input B
// - with buffer mode A, edge select C governs input A edges
// - edge select C picks input C edge; buffer B makes select D govern input B
// - clock select divides system clock by 2, 8, 32, or counts external rising edges
// - each flag raises its interrupt only while its enable bit is one
// - capture still loads its register when the flag is already set
`timescale 1ns/1ps
module ftsc_timer
	import ftsc_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        resetn_in,
	// power state
	input  wire logic        standby_in,
	// cpu register port
	input  wire logic [15:0] addr_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	input  wire logic [7:0]  wdata_in,
	output logic      [7:0]  rdata_out,
	// timer pins
	input  wire logic        capture_in_a,
	input  wire logic        capture_in_b,
	input  wire logic        capture_in_c,
	input  wire logic        capture_in_d,
	input  wire logic        ext_clock_in,
	// interrupt requests, bit 6 = capture a ... bit 0 = wrap
	output logic      [6:0]  irq_out
);

	logic [1:0]  rst_sync_r;
	logic        rst_n;
	ftsc_state_t st_r;
	ftsc_state_t st_nxt;

	logic [4:0]  agree;
	logic [4:0]  rise;
	logic [4:0]  fall;
	logic        buf_a;
	logic        buf_b;
	logic        cap_a_ev;
	logic        cap_b_ev;
	logic        cap_c_ev;
	logic        cap_d_ev;
	logic        tick;
	logic        match_a;
	logic        match_b;
	logic        wrap_ev;
	logic [6:0]  set_vec;
	logic        status_wr;

	function automatic logic edge_hit(input logic r, input logic f, input logic sel_rise);
		return sel_rise ? r : f;
	endfunction

	function automatic logic [15:0] join_bytes(input logic [7:0] hi, input logic [7:0] lo);
		return {hi, lo};
	endfunction

	// reset release through two flops; assertion is immediate
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// a pin change counts once the second and third stages agree
	assign agree = ~(st_r.sync1 ^ st_r.sync2);
	assign rise  = agree & st_r.sync2 & ~st_r.level;
	assign fall  = agree & ~st_r.sync2 & st_r.level;

	assign buf_a = st_r.control[CT_BUF_A];
	assign buf_b = st_r.control[CT_BUF_B];

	// in buffer mode the paired channel's edge select steers the buffered input
	assign cap_a_ev = edge_hit(rise[PIN_A], fall[PIN_A],
		buf_a ? st_r.control[CT_EDGE_C] : st_r.control[CT_EDGE_A]);
	assign cap_b_ev = edge_hit(rise[PIN_B], fall[PIN_B],
		buf_b ? st_r.control[CT_EDGE_D] : st_r.control[CT_EDGE_B]);
	assign cap_c_ev = edge_hit(rise[PIN_C], fall[PIN_C], st_r.control[CT_EDGE_C]);
	assign cap_d_ev = edge_hit(rise[PIN_D], fall[PIN_D], st_r.control[CT_EDGE_D]);

	// counter clock select
	always_comb begin
		unique case (ftsc_cks_t'(st_r.control[CT_CKS_HI:CT_CKS_LO]))
			CKS_DIV2:  tick = st_r.prescale[0];
			CKS_DIV8:  tick = &st_r.prescale[2:0];
			CKS_DIV32: tick = &st_r.prescale[4:0];
			CKS_EXT:   tick = rise[PIN_EXT];
		endcase
	end

	// compares are taken on each count so a held value flags only once
	assign match_a = st_r.count == st_r.cmp_a;
	assign match_b = st_r.count == st_r.cmp_b;
	assign wrap_ev = tick && st_r.count == COUNT_ALL_ONE;
	assign set_vec = {cap_a_ev, cap_b_ev, cap_c_ev, cap_d_ev,
		tick && match_a, tick && match_b, wrap_ev};
	assign status_wr = wr_in && addr_in == ADDR_STATUS;

	always_comb begin
		st_nxt = st_r;

		st_nxt.sync0 = {ext_clock_in, capture_in_d, capture_in_c, capture_in_b, capture_in_a};
		st_nxt.sync1 = st_r.sync0;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.level = (agree & st_r.sync2) | (~agree & st_r.level);
		st_nxt.prescale = st_r.prescale + 5'h01;

		if (tick) begin
			if (match_a && st_r.status[ST_CLR_MATCH]) begin
				st_nxt.count = 16'h0000;
			end else begin
				st_nxt.count = st_r.count + COUNT_ONE;
			end
		end

		// captures load regardless of the flag state
		if (cap_a_ev) begin
			if (buf_a) begin
				st_nxt.cap_c = st_r.cap_a;
			end
			st_nxt.cap_a = st_r.count;
		end
		// unbuffered, channel c owns its register, so a same-cycle capture a must not swallow it
		if (cap_c_ev && !buf_a) begin
			st_nxt.cap_c = st_r.count;
		end
		if (cap_b_ev) begin
			if (buf_b) begin
				st_nxt.cap_d = st_r.cap_b;
			end
			st_nxt.cap_b = st_r.count;
		end
		if (cap_d_ev && !buf_b) begin
			st_nxt.cap_d = st_r.count;
		end

		// register writes; the low byte completes a 16-bit write through temp
		if (wr_in) begin
			unique case (addr_in)
				ADDR_IRQ_EN: begin
					st_nxt.irq_en = {wdata_in[7:1], IRQ_EN_RST[0]};
				end
				ADDR_STATUS: begin
					st_nxt.status[7:1] = st_r.status[7:1] & wdata_in[7:1];
					st_nxt.status[ST_CLR_MATCH] = wdata_in[ST_CLR_MATCH];
				end
				ADDR_COUNT_HI, ADDR_COMPARE_HI: begin
					st_nxt.temp = wdata_in;
				end
				ADDR_COUNT_LO: begin
					st_nxt.count = join_bytes(st_r.temp, wdata_in);
				end
				ADDR_COMPARE_LO: begin
					if (st_r.out_ctrl[OC_SEL_B]) begin
						st_nxt.cmp_b = join_bytes(st_r.temp, wdata_in);
					end else begin
						st_nxt.cmp_a = join_bytes(st_r.temp, wdata_in);
					end
				end
				ADDR_CONTROL: begin
					st_nxt.control = wdata_in;
				end
				ADDR_OUT_CTRL: begin
					st_nxt.out_ctrl = wdata_in[4:0];
				end
				default: begin
				end
			endcase
		end

		// hardware set wins over a same-cycle clearing write
		st_nxt.status[7:1] = st_nxt.status[7:1] | set_vec;

		// reads; a counter or capture upper-byte read parks the lower byte in temp
		if (rd_in) begin
			unique case (addr_in)
				ADDR_IRQ_EN:     st_nxt.rdata = st_r.irq_en;
				ADDR_STATUS:     st_nxt.rdata = st_r.status;
				ADDR_CONTROL:    st_nxt.rdata = st_r.control;
				ADDR_OUT_CTRL:   st_nxt.rdata = OUT_CTRL_FILL | {3'b000, st_r.out_ctrl};
				ADDR_COMPARE_HI: st_nxt.rdata = st_r.out_ctrl[OC_SEL_B] ? st_r.cmp_b[15:8] : st_r.cmp_a[15:8];
				ADDR_COMPARE_LO: st_nxt.rdata = st_r.out_ctrl[OC_SEL_B] ? st_r.cmp_b[7:0] : st_r.cmp_a[7:0];
				ADDR_COUNT_HI: begin
					st_nxt.rdata = st_r.count[15:8];
					st_nxt.temp = st_r.count[7:0];
				end
				ADDR_CAP_A_HI: begin
					st_nxt.rdata = st_r.cap_a[15:8];
					st_nxt.temp = st_r.cap_a[7:0];
				end
				ADDR_CAP_B_HI: begin
					st_nxt.rdata = st_r.cap_b[15:8];
					st_nxt.temp = st_r.cap_b[7:0];
				end
				ADDR_CAP_C_HI: begin
					st_nxt.rdata = st_r.cap_c[15:8];
					st_nxt.temp = st_r.cap_c[7:0];
				end
				ADDR_CAP_D_HI: begin
					st_nxt.rdata = st_r.cap_d[15:8];
					st_nxt.temp = st_r.cap_d[7:0];
				end
				ADDR_COUNT_LO, ADDR_CAP_A_LO, ADDR_CAP_B_LO, ADDR_CAP_C_LO, ADDR_CAP_D_LO: begin
					st_nxt.rdata = st_r.temp;
				end
				default: st_nxt.rdata = UNMAPPED_READ;
			endcase
		end

		st_nxt.irq = st_r.status[7:1] & st_r.irq_en[7:1];

		// standby holds every register except rdata at its reset value; pin sync keeps running
		if (standby_in) begin
			st_nxt.status   = STATUS_RST;
			st_nxt.control  = CONTROL_RST;
			st_nxt.irq_en   = IRQ_EN_RST;
			st_nxt.out_ctrl = 5'h00;
			st_nxt.count    = 16'h0000;
			st_nxt.cmp_a    = 16'h0000;
			st_nxt.cmp_b    = 16'h0000;
			st_nxt.cap_a    = 16'h0000;
			st_nxt.cap_b    = 16'h0000;
			st_nxt.cap_c    = 16'h0000;
			st_nxt.cap_d    = 16'h0000;
			st_nxt.temp     = 8'h00;
			st_nxt.prescale = 5'h00;
			st_nxt.irq      = 7'h00;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.irq_en <= IRQ_EN_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_out = st_r.rdata;
	assign irq_out   = st_r.irq;

	// checks
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n);

	sequence s_cap_a_plain;
		cap_a_ev && !buf_a && !standby_in;
	endsequence

	sequence s_cap_a_buffered;
		cap_a_ev && buf_a && !standby_in;
	endsequence

	sequence s_clear_write(int b);
		status_wr && !wdata_in[b] && !standby_in;
	endsequence

	chk_flags_hw_only: assert property (
		((st_r.status[7:1] & ~$past(st_r.status[7:1]) & ~$past(set_vec)) == 7'h00))
		else $error("status flag rose without a hardware event");

	chk_standby_clear: assert property (
		standby_in |=> st_r.status == STATUS_RST && st_r.control == CONTROL_RST)
		else $error("standby did not clear status and control");

	chk_capture_a_load: assert property (
		s_cap_a_plain |=> st_r.cap_a == $past(st_r.count) && st_r.status[ST_CAP_A])
		else $error("capture A did not load counter or set flag");

	chk_buffer_a_shift: assert property (
		s_cap_a_buffered |=> st_r.cap_c == $past(st_r.cap_a) && st_r.cap_a == $past(st_r.count))
		else $error("buffered capture A did not shift into C");

	chk_capture_b_load: assert property (
		cap_b_ev && !standby_in |=> st_r.cap_b == $past(st_r.count) && st_r.status[ST_CAP_B])
		else $error("capture B did not load counter or set flag");

	chk_cap_c_buffered: assert property (
		cap_c_ev && buf_a && !cap_a_ev && !standby_in |=> $stable(st_r.cap_c) && st_r.status[ST_CAP_C])
		else $error("input C captured while buffer mode A on");

	chk_cap_d_plain: assert property (
		cap_d_ev && !buf_b && !cap_b_ev && !standby_in |=> st_r.cap_d == $past(st_r.count) && st_r.status[ST_CAP_D])
		else $error("capture D did not load counter");

	chk_compare_a_flag: assert property (
		tick && match_a && !standby_in |=> st_r.status[ST_CMP_A])
		else $error("compare match A did not set flag");

	chk_compare_b_flag: assert property (
		tick && match_b && !standby_in |=> st_r.status[ST_CMP_B])
		else $error("compare match B did not set flag");

	chk_wrap_flag: assert property (
		tick && st_r.count == COUNT_ALL_ONE && !standby_in
		|=> st_r.status[ST_WRAP] && (st_r.count == 16'h0000 || $past(wr_in && addr_in == ADDR_COUNT_LO)))
		else $error("counter wrap did not set flag");

	chk_clear_on_match: assert property (
		tick && match_a && st_r.status[ST_CLR_MATCH] && !standby_in && !(wr_in && addr_in == ADDR_COUNT_LO)
		|=> st_r.count == 16'h0000)
		else $error("counter not cleared on compare match A");

	chk_div8_spacing: assert property (
		st_r.control[CT_CKS_HI:CT_CKS_LO] == CKS_DIV8 && tick && !standby_in && !wr_in
		|=> !tick [*7])
		else $error("divide-by-8 tick came early");

	chk_irq_gate: assert property (
		irq_out[6] |-> $past(st_r.irq_en[ST_CAP_A]) && $past(st_r.status[ST_CAP_A]))
		else $error("capture A interrupt raised while disabled");

	chk_set_wins: assert property (
		s_clear_write(ST_WRAP) ##0 wrap_ev |=> st_r.status[ST_WRAP])
		else $error("clearing write beat a same-cycle wrap event");

	chk_edge_a_rise: assert property (
		rise[PIN_A] && !buf_a && st_r.control[CT_EDGE_A] |-> cap_a_ev)
		else $error("rising edge on A missed with edge select A set");

endmodule

// ---- testbench/ftsc_cpu_model.sv ----
// host cpu model: byte and paired word accesses on the timer register port
`timescale 1ns/1ps
module ftsc_cpu_model
	import ftsc_pkg::*;
(
	// clock
	input  wire logic        clk_in,
	// register port
	output logic      [15:0] addr_out,
	output logic             wr_out,
	output logic             rd_out,
	output logic      [7:0]  wdata_out,
	input  wire logic [7:0]  rdata_in
);
	initial begin
		addr_out  = 16'h0000;
		wr_out    = 1'b0;
		rd_out    = 1'b0;
		wdata_out = 8'h00;
	end

	// released address and data show the inverse so nothing leans on stale values
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out  <= a;
		wdata_out <= d;
		wr_out    <= 1'b1;
		@(posedge clk_in);
		wr_out    <= 1'b0;
		addr_out  <= ~a;
		wdata_out <= ~d;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out   <= 1'b1;
		@(posedge clk_in);
		rd_out   <= 1'b0;
		addr_out <= ~a;
		@(negedge clk_in);
		d = rdata_in;
	endtask

	// upper byte first, lower byte second, nothing in between
	task automatic wr16(input logic [15:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 16'h0001, v[7:0]);
	endtask

	task automatic rd16(input logic [15:0] a, output logic [15:0] v);
		logic [7:0] h;
		logic [7:0] l;
		rd(a, h);
		rd(a + 16'h0001, l);
		v = {h, l};
	endtask

	task automatic clear_flags();
		logic [7:0] d;
		rd(ADDR_STATUS, d);
		wr(ADDR_STATUS, 8'h00);
	endtask
endmodule

// ---- testbench/ftsc_timer_tb.sv ----
// self-checking bench for the free timer status/control block
`timescale 1ns/1ps
module ftsc_timer_tb
	import ftsc_pkg::*;
;
	logic        sys_clk;
	logic        resetn;
	logic        standby;
	logic [3:0]  cap_pins;
	logic        ext_clk;
	logic [15:0] addr;
	logic        wr;
	logic        rd;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic [6:0]  irq;
	logic [7:0]  m_stat;
	logic [7:0]  m_ctrl;
	logic [15:0] m_count;
	logic [15:0] m_cap [4];
	logic [7:0]  cfgs [4];
	logic [31:0] seed;
	logic [15:0] w;
	int          n_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;

	ftsc_timer uut (
		.sys_clk_in   (sys_clk),
		.resetn_in    (resetn),
		.standby_in   (standby),
		.addr_in      (addr),
		.wr_in        (wr),
		.rd_in        (rd),
		.wdata_in     (wdata),
		.rdata_out    (rdata),
		.capture_in_a (cap_pins[0]),
		.capture_in_b (cap_pins[1]),
		.capture_in_c (cap_pins[2]),
		.capture_in_d (cap_pins[3]),
		.ext_clock_in (ext_clk),
		.irq_out      (irq)
	);

	ftsc_cpu_model host (
		.clk_in    (sys_clk),
		.addr_out  (addr),
		.wr_out    (wr),
		.rd_out    (rd),
		.wdata_out (wdata),
		.rdata_in  (rdata)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			conclude();
		end
	end

	function automatic logic [15:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] mask, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		chk_byte(d & mask, exp & mask);
	endtask

	task automatic set_count(input logic [15:0] v);
		host.wr16(ADDR_COUNT_HI, v);
		m_count = v;
	endtask

	// expected effect of one capture event; the counter is frozen so the value is exact
	task automatic model_cap(input int ch);
		if (ch < 2 && m_ctrl[3-ch])
			m_cap[ch+2] = m_cap[ch];
		if (ch < 2 || !m_ctrl[5-ch])
			m_cap[ch] = m_count;
		m_stat = m_stat | (8'h80 >> ch);
	endtask

	// the unselected edge comes first, so a wrong polarity shows up as a wrong capture
	task automatic pin_event(input int ch);
		logic rise;
		rise = (ch < 2 && m_ctrl[3-ch]) ? m_ctrl[5-ch] : m_ctrl[7-ch];
		@(posedge sys_clk);
		cap_pins[ch] <= ~rise;
		repeat (8) @(posedge sys_clk);
		cap_pins[ch] <= rise;
		repeat (8) @(posedge sys_clk);
		model_cap(ch);
	endtask

	task automatic ext_pulse();
		@(posedge sys_clk);
		ext_clk <= 1'b1;
		repeat (5) @(posedge sys_clk);
		ext_clk <= 1'b0;
		repeat (5) @(posedge sys_clk);
	endtask

	task automatic check_all(input logic [7:0] mask);
		logic [15:0] v;
		rd_chk(ADDR_STATUS, mask, m_stat);
		for (int ch = 0; ch < 4; ch++) begin
			host.rd16(ADDR_CAP_A_HI + 16'(2 * ch), v);
			chk_word(v, m_cap[ch]);
		end
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		standby = 1'b0;
		cap_pins = 4'hF;
		ext_clk = 1'b0;
		seed = 32'd43659;
		m_stat = 8'h00;
		m_cap = '{default: 16'h0000};
		cfgs = '{8'h03, 8'hF3, 8'h2F, 8'hDF};
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		// both compares reset to zero and the counter starts at zero on /2, so both match flags come up
		rd_chk(ADDR_STATUS, 8'hFF, 8'h0C);
		rd_chk(ADDR_CONTROL, 8'hFF, 8'h00);
		rd_chk(ADDR_IRQ_EN, 8'hFF, 8'h01);
		w = xorshift();
		host.wr(ADDR_CONTROL, w[7:0]);
		rd_chk(ADDR_CONTROL, 8'hFF, w[7:0]);
		host.wr(ADDR_CONTROL, 8'h03);
		set_count(xorshift());
		host.clear_flags();
		host.wr(ADDR_STATUS, 8'hFF);
		rd_chk(ADDR_STATUS, 8'hFF, 8'h01);
		host.clear_flags();
		foreach (cfgs[i]) begin
			m_ctrl = cfgs[i];
			host.wr(ADDR_CONTROL, m_ctrl);
			for (int ch = 0; ch < 4; ch++) begin
				set_count(xorshift());
				pin_event(ch);
			end
			set_count(xorshift());
			pin_event(0);
			check_all(8'hFF);
			host.clear_flags();
			m_stat = 8'h00;
		end
		w = xorshift();
		w[15:14] = 2'b01;
		host.wr(ADDR_STATUS, 8'h01);
		host.wr(ADDR_OUT_CTRL, 8'h00);
		host.wr16(ADDR_COMPARE_HI, w);
		set_count(w - 16'h0003);
		repeat (4) ext_pulse();
		rd_chk(ADDR_STATUS, 8'hFF, 8'h09);
		host.rd16(ADDR_COUNT_HI, w);
		chk_word(w, 16'h0000);
		host.wr(ADDR_IRQ_EN, 8'hFE);
		repeat (3) @(negedge sys_clk);
		chk_byte({1'b0, irq}, 8'h04);
		host.wr(ADDR_IRQ_EN, 8'h00);
		repeat (3) @(negedge sys_clk);
		chk_byte({1'b0, irq}, 8'h00);
		rd_chk(ADDR_IRQ_EN, 8'hFF, 8'h01);
		host.clear_flags();
		host.wr(ADDR_OUT_CTRL, 8'h10);
		host.wr16(ADDR_COMPARE_HI, 16'h0000);
		set_count(16'hFFFF);
		repeat (2) ext_pulse();
		rd_chk(ADDR_STATUS, 8'hFF, 8'h06);
		host.rd16(ADDR_COUNT_HI, w);
		chk_word(w, 16'h0001);
		@(posedge sys_clk);
		standby <= 1'b1;
		repeat (2) @(posedge sys_clk);
		standby <= 1'b0;
		m_stat = 8'h0C;
		m_cap = '{default: 16'h0000};
		rd_chk(ADDR_CONTROL, 8'hFF, 8'h00);
		check_all(8'hFF);
		// 64 system clock cycles pass between the low-byte write and the upper-byte read
		for (int code = 0; code < 3; code++) begin
			host.wr(ADDR_CONTROL, 8'(code));
			set_count(xorshift());
			repeat (63) @(posedge sys_clk);
			host.rd16(ADDR_COUNT_HI, w);
			chk_word(w, m_count + 16'(64 >> (2 * code + 1)));
		end
		conclude();
	end
endmodule
